// ==== dv/register_reset_init_sva.sv ====
// Port assertions for the reset and wake-up initialiser.
// Assumes one clock domain; bound to every instance of the design.
module register_reset_init_sva
  import reset_init_pkg::*;
(
  input wire logic                        core_clk_i,
  input wire logic                        rst_n_i,
  input wire reset_init_pkg::event_t      event_i,
  input wire reset_init_pkg::power_mode_t power_mode_i,
  input wire logic                        stack_fault_reset_enable_i,
  input wire logic                        high_prio_global_irq_en_i,
  input wire logic                        low_prio_global_irq_en_i,
  input wire logic [PC_W-1:0]             pc_i,
  input wire logic                        osc_frees_port_a_input_hi_i,
  input wire logic [PC_W-1:0]             pc_o,
  input wire logic                        core_reset_o,
  input wire logic [7:0]                  stack_top_low_o,
  input wire logic [7:0]                  hw_stack_pointer_o,
  input wire logic [7:0]                  irq_control_reg_o,
  input wire logic [7:0]                  reset_control_status_o,
  input wire logic [7:0]                  timer1_control_o,
  input wire logic [7:0]                  timer2_period_o,
  input wire logic [7:0]                  port_a_latch_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ==========================================================================
  // Decoded event kinds
  logic irq_go;
  logic irq_any;
  logic wdt_wake;
  logic under_soft;
  logic warm;
  assign irq_any = event_i.valid && event_i.cause == EV_IRQ_WAKE;
  assign irq_go = irq_any && (high_prio_global_irq_en_i || low_prio_global_irq_en_i);
  assign wdt_wake = event_i.valid && event_i.cause == EV_WDT && power_mode_i[1];
  assign under_soft = event_i.valid && event_i.cause == EV_STACK_UNDER
                      && !stack_fault_reset_enable_i;
  assign warm = event_i.valid && (event_i.cause == EV_MASTER_CLEAR || event_i.cause == EV_RESET_INSTR);

  // ==========================================================================
  // Properties
  property p_vector;
    irq_go |=> pc_o == ($past(event_i.high_prio) ? HIGH_IRQ_VEC : LOW_IRQ_VEC);
  endproperty
  a_vector: assert property (p_vector) else $error("vector not loaded");
  property p_tos;
    irq_go |=> stack_top_low_o == $past(pc_i[7:0]);
  endproperty
  a_tos: assert property (p_tos) else $error("stack top not loaded");
  property p_ptr;
    irq_go |=> hw_stack_pointer_o[4:0] == $past(hw_stack_pointer_o[4:0]) + 5'h01;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not advanced");
  property p_flags;
    irq_any |=> (irq_control_reg_o & $past(event_i.irq_ctrl_set)) == $past(event_i.irq_ctrl_set);
  endproperty
  a_flags: assert property (p_flags) else $error("wake flag missing");
  property p_unimpl;
    !hw_stack_pointer_o[5] && !reset_control_status_o[5] && !reset_control_status_o[7];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
  property p_port_a_input;
    !osc_frees_port_a_input_hi_i |=> port_a_latch_o[7:6] == 2'b00;
  endproperty
  a_port_a_input: assert property (p_port_a_input) else $error("port bits live");
  property p_wdt;
    wdt_wake |=> pc_o == $past(pc_i) + RESUME_STEP && !core_reset_o;
  endproperty
  a_wdt: assert property (p_wdt) else $error("wake resume wrong");
  property p_under;
    under_soft |=> hw_stack_pointer_o[SP_UNDER] && $stable(pc_o) && !core_reset_o;
  endproperty
  a_under: assert property (p_under) else $error("underflow handling wrong");
  property p_pr2;
    event_i.valid |=> timer2_period_o == TIMER2_PERIOD_RST;
  endproperty
  a_pr2: assert property (p_pr2) else $error("period not all ones");
  property p_warm;
    warm |=> core_reset_o && !timer1_control_o[TMR1_CLR_BIT] && pc_o == RESET_VECTOR;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset wrong");

  // Main scenarios reached
  c_irq: cover property (irq_go);
  c_wdt: cover property (wdt_wake);
  c_under: cover property (under_soft);
  c_warm: cover property (warm);
endmodule : register_reset_init_sva

bind register_reset_init register_reset_init_sva sva_i (.*);

// ==== dv/test_register_reset_init.sv ====
// Self-checking bench for the reset and wake-up initialiser.
// Assumes the design package is compiled first; bench drives all ports.
module test_register_reset_init
  import reset_init_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Stimulus and observed signals
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  event_t          ev = '0;
  power_mode_t     pm = PM_FULL;
  logic            sfre = 1'b0;
  logic            gh = 1'b0;
  logic            gl = 1'b0;
  logic            ofree = 1'b0;
  logic            osd = 1'b1;
  logic            ios = 1'b1;
  logic [PC_W-1:0] pc = '0;
  logic [PC_W-1:0] pe;
  port_a_t         pa = '0;
  logic [PC_W-1:0] pc_q;
  logic            core_rst;
  logic            kept;
  logic [4:0]      tu;
  logic [7:0]      th, tl, sp, ic, pf, rc, oc, t0, t1, t2, pi, pl, pd, m8;
  logic [31:0]     rnd = 32'h0000_22BA;
  int              fails = 0;
  int              check_count = 0;
  int              cyc = 0;
  int              sp_m = 0;
  cause_t          warm_list [3] = '{EV_MASTER_CLEAR, EV_RESET_INSTR, EV_WDT};

  register_reset_init register_reset_init_i (
    .core_clk_i(clk), .rst_n_i(rst_n), .event_i(ev), .power_mode_i(pm),
    .stack_fault_reset_enable_i(sfre), .high_prio_global_irq_en_i(gh),
    .low_prio_global_irq_en_i(gl), .pc_i(pc), .osc_frees_port_a_input_hi_i(ofree),
    .osc_start_done_i(osd), .int_osc_stable_i(ios), .port_a_i(pa), .pc_o(pc_q),
    .core_reset_o(core_rst), .stack_top_upper_o(tu), .stack_top_high_o(th),
    .stack_top_low_o(tl), .hw_stack_pointer_o(sp), .irq_control_reg_o(ic),
    .periph_irq_flag_reg_o(pf), .reset_control_status_o(rc), .oscillator_control_o(oc),
    .timer0_control_o(t0), .timer1_control_o(t1), .timer2_period_o(t2),
    .port_a_input_o(pi), .port_a_latch_o(pl), .port_a_direction_o(pd));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction : lfsr

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One-cycle event pulse with random flag bits
  task automatic send(input cause_t c, input logic hp);
    @(posedge clk);
    #1;
    rnd = lfsr(rnd);
    ev = '{1'b1, c, hp, rnd[7:0], rnd[15:8]};
    osd = rnd[16];
    ios = rnd[17];
    @(posedge clk);
    #1;
    ev.valid = 1'b0;
  endtask : send

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // Free-running clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      fails++;
      finish_test();
    end
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    check("pc", pc_q, RESET_VECTOR);
    check("t0", t0, TIMER0_CTRL_RST);
    check("t2", t2, TIMER2_PERIOD_RST);
    check("reset_control_status", rc, 8'h1C);
    check("osc", oc, 8'h40);
    #1 rst_n = 1'b1;
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      pc = rnd[20:0];
      gh = i[0];
      gl = i[1];
      send(EV_IRQ_WAKE, i[2]);
      pe = (gh | gl) ? (i[2] ? HIGH_IRQ_VEC : LOW_IRQ_VEC) : pc + RESUME_STEP;
      if (gh | gl)
      begin
        sp_m = (sp_m + 1) % 32;
        check("tos", {tu, th, tl}, pc);
      end
      check("pc", pc_q, pe);
      check("sp", sp[4:0], sp_m);
      check("ic", ic & ev.irq_ctrl_set, ev.irq_ctrl_set);
      check("pf", pf & ev.pir_set, ev.pir_set);
      check("pd", rc[RC_PD], 1'b0);
      check("t2", t2, 8'hFF);
      check("iofs", oc[OSC_IOFS_BIT], ios);
    end
    $display("irq test done");
    for (int m = 2; m < 4; m++)
    begin
      pm = power_mode_t'(m);
      rnd = lfsr(rnd);
      pc = rnd[20:0];
      send(EV_WDT, 1'b0);
      check("pc", pc_q, pc + RESUME_STEP);
      check("rst", core_rst, 1'b0);
      check("to", rc[RC_TO], 1'b0);
      check("iofs", oc[OSC_IOFS_BIT], ios);
    end
    pm = PM_FULL;
    pe = pc_q;
    send(EV_STACK_UNDER, 1'b0);
    check("under", sp[SP_UNDER], 1'b1);
    check("rst", core_rst, 1'b0);
    check("pc", pc_q, pe);
    $display("wake test done");
    for (int r = 0; r < 3; r++)
    begin
      kept = ic[IRQ_CTRL_KEEP];
      send(warm_list[r], 1'b0);
      check("rst", core_rst, 1'b1);
      check("t1", t1[TMR1_CLR_BIT], 1'b0);
      check("t0", t0, 8'hFF);
      check("pc", pc_q, RESET_VECTOR);
      check("ic0", ic[IRQ_CTRL_KEEP], kept);
      check("sp", sp[SP_UNDER:0], 7'h40);
      check("osc", oc, OSC_CTRL_RST | {4'h0, osd, 3'h0});
    end
    $display("warm reset test done");
    // Stack fault resets, cold resets and a mid-run pin reset
    sfre = 1'b1;
    send(EV_STACK_FULL, 1'b0);
    check("rst", core_rst, 1'b1);
    check("full", sp[SP_FULL], 1'b1);
    check("t1", t1[TMR1_CLR_BIT], 1'b0);
    send(EV_STACK_UNDER, 1'b0);
    check("rst", core_rst, 1'b1);
    check("pc", pc_q, RESET_VECTOR);
    sfre = 1'b0;
    send(EV_BOR, 1'b0);
    check("reset_control_status", {rc[RC_RI], rc[RC_TO], rc[RC_PD], rc[RC_BOR]}, 4'hE);
    check("ic", ic, IRQ_CTRL_RST);
    check("t0", t0, TIMER0_CTRL_RST);
    send(EV_POR, 1'b0);
    check("sp", sp, 8'h00);
    check("reset_control_status", rc, RESET_CONTROL_STATUS_RST);
    rst_n = 1'b0;
    #1;
    check("rst", core_rst, 1'b1);
    check("osc", oc, OSC_CTRL_RST);
    @(posedge clk);
    #1 rst_n = 1'b1;
    $display("cold reset test done");
    for (int k = 0; k < 6; k++)
    begin
      rnd = lfsr(rnd);
      pa = {rnd[7:0], rnd[15:8], rnd[23:16]};
      ofree = k[0];
      @(posedge clk);
      #1;
      m8 = ofree ? 8'hFF : PORT_A_INPUT_LOW6;
      check("pin", pi, pa.pins & m8);
      check("lat", pl, pa.latch & m8);
      check("dir", pd, pa.direction & m8);
      check("imp", {rc[7], rc[5], sp[5]}, 3'h0);
    end
    $display("port test done");
    finish_test();
  end
endmodule : test_register_reset_init

// ==== rtl/register_reset_init.sv ====
// Reset and wake-up initialiser for core and peripheral registers.
// Assumes events are one-cycle pulses, synchronous to core_clk_i.
module register_reset_init
  import reset_init_pkg::*;
#(
  parameter logic SW_BOR_ON = 1'b0
)(
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_n_i,
  input  wire reset_init_pkg::event_t        event_i,
  input  wire reset_init_pkg::power_mode_t   power_mode_i,
  input  wire logic                          stack_fault_reset_enable_i,
  input  wire logic                          high_prio_global_irq_en_i,
  input  wire logic                          low_prio_global_irq_en_i,
  input  wire logic [reset_init_pkg::PC_W-1:0] pc_i,
  input  wire logic                          osc_frees_port_a_input_hi_i,
  input  wire logic                          osc_start_done_i,
  input  wire logic                          int_osc_stable_i,
  input  wire reset_init_pkg::port_a_t       port_a_i,
  output logic [reset_init_pkg::PC_W-1:0]    pc_o,
  output logic                               core_reset_o,
  output logic [4:0]                         stack_top_upper_o,
  output logic [7:0]                         stack_top_high_o,
  output logic [7:0]                         stack_top_low_o,
  output logic [7:0]                         hw_stack_pointer_o,
  output logic [7:0]                         irq_control_reg_o,
  output logic [7:0]                         periph_irq_flag_reg_o,
  output logic [7:0]                         reset_control_status_o,
  output logic [7:0]                         oscillator_control_o,
  output logic [7:0]                         timer0_control_o,
  output logic [7:0]                         timer1_control_o,
  output logic [7:0]                         timer2_period_o,
  output logic [7:0]                         port_a_input_o,
  output logic [7:0]                         port_a_latch_o,
  output logic [7:0]                         port_a_direction_o
);
  import reset_init_pkg::*;

  // ==========================================================================
  // Event decode
  logic          is_por;
  logic          is_cold;
  logic          is_warm;
  logic          is_reset;
  logic          is_irq_wake;
  logic          gie_any;
  logic          in_low_power;
  logic          wdt_wake;
  logic          is_wake;
  logic          under_flag_only;
  logic [PTR_W-1:0] sp_ptr;
  logic [BYTE_W-1:0] sp_flags;
  logic [PC_W-1:0] next_pc;

  // Classify the incoming event
  always_comb
  begin
    is_por          = 1'b0;
    is_cold         = 1'b0;
    is_warm         = 1'b0;
    is_irq_wake     = 1'b0;
    wdt_wake        = 1'b0;
    under_flag_only = 1'b0;
    in_low_power    = (power_mode_i == PM_IDLE) || (power_mode_i == PM_SLEEP);
    if (event_i.valid)
    begin
      unique case (event_i.cause)
        EV_POR:         begin is_por = 1'b1; is_cold = 1'b1; end
        EV_BOR:         is_cold = 1'b1;
        EV_MASTER_CLEAR:        is_warm = 1'b1;
        EV_RESET_INSTR: is_warm = 1'b1;
        EV_STACK_FULL:  is_warm = stack_fault_reset_enable_i;
        EV_STACK_UNDER:
        begin
          is_warm         = stack_fault_reset_enable_i;
          under_flag_only = !stack_fault_reset_enable_i;
        end
        EV_WDT:
        begin
          wdt_wake = in_low_power;
          is_warm  = !in_low_power;
        end
        EV_IRQ_WAKE:    is_irq_wake = 1'b1;
        default:        ;
      endcase
    end
  end

  assign is_reset = is_cold || is_warm;
  assign is_wake  = wdt_wake || is_irq_wake;
  assign gie_any  = high_prio_global_irq_en_i || low_prio_global_irq_en_i;
  assign sp_ptr   = hw_stack_pointer_o[PTR_W-1:0];
  assign sp_flags = hw_stack_pointer_o & ~8'h1F;

  // Program counter target selection
  always_comb
  begin
    next_pc = pc_o;
    if (is_reset)
      next_pc = RESET_VECTOR;
    else if (is_irq_wake && gie_any)
      next_pc = event_i.high_prio ? HIGH_IRQ_VEC : LOW_IRQ_VEC;
    else if (is_wake)
      next_pc = pc_i + RESUME_STEP;
  end

  // ==========================================================================
  // Program counter and reset pulse
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pc_o         <= RESET_VECTOR;
      core_reset_o <= 1'b1;
    end
    else
    begin
      pc_o         <= next_pc;
      core_reset_o <= is_reset;
    end
  end

  // ==========================================================================
  // Hardware stack top and pointer
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stack_top_upper_o  <= 5'h00;
      stack_top_high_o   <= 8'h00;
      stack_top_low_o    <= 8'h00;
      hw_stack_pointer_o <= 8'h00;
    end
    else if (is_reset)
    begin
      stack_top_upper_o  <= 5'h00;
      stack_top_high_o   <= 8'h00;
      stack_top_low_o    <= 8'h00;
      // Flags kept on warm and brown-out resets, cleared on power-on
      hw_stack_pointer_o <= is_por ? 8'h00 : sp_flags;
      if (event_i.cause == EV_STACK_FULL)
        hw_stack_pointer_o[SP_FULL] <= 1'b1;
      if (event_i.cause == EV_STACK_UNDER)
        hw_stack_pointer_o[SP_UNDER] <= 1'b1;
    end
    else if (is_irq_wake && gie_any)
    begin
      stack_top_upper_o  <= pc_i[20:16];
      stack_top_high_o   <= pc_i[15:8];
      stack_top_low_o    <= pc_i[7:0];
      hw_stack_pointer_o <= (sp_flags | {3'h0, sp_ptr + 5'h01}) & SP_IMPL;
    end
    else if (under_flag_only)
      hw_stack_pointer_o[SP_UNDER] <= 1'b1;
  end

  // ==========================================================================
  // Wake cause flags
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_control_reg_o     <= IRQ_CTRL_RST;
      periph_irq_flag_reg_o <= PIR_RST;
    end
    else if (is_reset)
    begin
      // Bit 0 cleared on cold resets, unchanged on warm resets
      irq_control_reg_o     <= is_cold ? IRQ_CTRL_RST :
                               (irq_control_reg_o & 8'h01);
      periph_irq_flag_reg_o <= PIR_RST;
    end
    else if (is_irq_wake)
    begin
      irq_control_reg_o     <= irq_control_reg_o | event_i.irq_ctrl_set;
      periph_irq_flag_reg_o <= periph_irq_flag_reg_o | event_i.pir_set;
    end
  end

  // ==========================================================================
  // Reset cause status
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reset_control_status_o <= RESET_CONTROL_STATUS_RST | {1'b0, SW_BOR_ON, 6'h00};
    else if (event_i.valid)
    begin
      unique case (event_i.cause)
        EV_POR:
        begin
          reset_control_status_o <= RESET_CONTROL_STATUS_RST | {1'b0, SW_BOR_ON, 6'h00};
        end
        EV_BOR:
        begin
          reset_control_status_o[RC_RI]  <= 1'b1;
          reset_control_status_o[RC_TO]  <= 1'b1;
          reset_control_status_o[RC_PD]  <= 1'b1;
          reset_control_status_o[RC_BOR] <= 1'b0;
          if (!SW_BOR_ON)
            reset_control_status_o[RC_SBOREN] <= 1'b0;
        end
        EV_RESET_INSTR: reset_control_status_o[RC_RI] <= 1'b0;
        EV_MASTER_CLEAR:
        begin
          if (power_mode_i != PM_FULL)
            reset_control_status_o[RC_TO] <= 1'b1;
          if (in_low_power)
            reset_control_status_o[RC_PD] <= 1'b0;
        end
        EV_WDT:
        begin
          reset_control_status_o[RC_TO] <= 1'b0;
          if (in_low_power)
            reset_control_status_o[RC_PD] <= 1'b0;
        end
        EV_IRQ_WAKE: reset_control_status_o[RC_PD] <= 1'b0;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Oscillator status
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      oscillator_control_o <= OSC_CTRL_RST;
    else if (is_reset)
    begin
      oscillator_control_o              <= OSC_CTRL_RST;
      oscillator_control_o[OSC_STS_BIT] <= osc_start_done_i;
    end
    else if (is_wake)
      oscillator_control_o[OSC_IOFS_BIT] <= int_osc_stable_i;
  end

  // ==========================================================================
  // Timer control and period
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      timer0_control_o <= TIMER0_CTRL_RST;
      timer1_control_o <= TIMER1_CTRL_RST;
      timer2_period_o  <= TIMER2_PERIOD_RST;
    end
    else
    begin
      if (is_reset || is_wake)
        timer2_period_o <= TIMER2_PERIOD_RST;
      if (is_reset)
        timer0_control_o <= TIMER0_CTRL_RST;
      if (is_cold)
        timer1_control_o <= TIMER1_CTRL_RST;
      else if (is_warm)
        timer1_control_o[TMR1_CLR_BIT] <= 1'b0;
    end
  end

  // ==========================================================================
  // Port A gating of the oscillator-shared bits
  logic [BYTE_W-1:0] port_a_input_mask;

  assign port_a_input_mask = PORT_A_INPUT_LOW6 | (osc_frees_port_a_input_hi_i ? PORT_A_INPUT_HI2 : 8'h00);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_a_input_o     <= 8'h00;
      port_a_latch_o     <= 8'h00;
      port_a_direction_o <= 8'h00;
    end
    else
    begin
      port_a_input_o     <= port_a_i.pins & port_a_input_mask;
      port_a_latch_o     <= port_a_i.latch & port_a_input_mask;
      port_a_direction_o <= port_a_i.direction & port_a_input_mask;
    end
  end

endmodule : register_reset_init

// ==== shared/reset_init_pkg.sv ====
// Constants, types and event carrier for the reset and wake-up initialiser.
// Assumes one core clock; events arrive as single-cycle pulses from the core.
package reset_init_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_W   = 21;
  localparam int PTR_W  = 5;
  localparam int BYTE_W = 8;

  // ==========================================================================
  // Vectors and resume offset
  localparam logic [PC_W-1:0] RESET_VECTOR   = 21'h0_0000;
  localparam logic [PC_W-1:0] HIGH_IRQ_VEC   = 21'h0_0008;
  localparam logic [PC_W-1:0] LOW_IRQ_VEC    = 21'h0_0018;
  localparam logic [PC_W-1:0] RESUME_STEP    = 21'h0_0002;

  // ==========================================================================
  // Reset values
  localparam logic [BYTE_W-1:0] TIMER0_CTRL_RST  = 8'hFF;
  localparam logic [BYTE_W-1:0] TIMER2_PERIOD_RST = 8'hFF;
  localparam logic [BYTE_W-1:0] TIMER1_CTRL_RST  = 8'h00;
  localparam logic [BYTE_W-1:0] IRQ_CTRL_RST     = 8'h00;
  localparam logic [BYTE_W-1:0] PIR_RST          = 8'h00;
  localparam logic [BYTE_W-1:0] OSC_CTRL_RST     = 8'h40;
  localparam logic [BYTE_W-1:0] RESET_CONTROL_STATUS_RST         = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int TMR1_CLR_BIT   = 6;
  localparam int OSC_STS_BIT    = 3;
  localparam int OSC_IOFS_BIT   = 1;
  localparam int RC_SBOREN      = 6;
  localparam int RC_RI          = 4;
  localparam int RC_TO          = 3;
  localparam int RC_PD          = 2;
  localparam int RC_POR         = 1;
  localparam int RC_BOR         = 0;
  localparam int SP_FULL        = 7;
  localparam int SP_UNDER       = 6;
  localparam int IRQ_CTRL_KEEP  = 0;

  // Implemented-bit masks; unimplemented bits read zero
  localparam logic [BYTE_W-1:0] RESET_CONTROL_STATUS_IMPL  = 8'hDF;
  localparam logic [BYTE_W-1:0] SP_IMPL    = 8'hDF;
  localparam logic [BYTE_W-1:0] PORT_A_INPUT_LOW6 = 8'h3F;
  localparam logic [BYTE_W-1:0] PORT_A_INPUT_HI2  = 8'hC0;

  // ==========================================================================
  // Event causes and power modes
  typedef enum logic [3:0] {
    EV_POR         = 4'h0,
    EV_BOR         = 4'h1,
    EV_MASTER_CLEAR        = 4'h2,
    EV_WDT         = 4'h3,
    EV_RESET_INSTR = 4'h4,
    EV_STACK_FULL  = 4'h5,
    EV_STACK_UNDER = 4'h6,
    EV_IRQ_WAKE    = 4'h7
  } cause_t;

  typedef enum logic [1:0] {
    PM_FULL  = 2'h0,
    PM_RUN   = 2'h1,
    PM_IDLE  = 2'h2,
    PM_SLEEP = 2'h3
  } power_mode_t;

  typedef struct packed {
    logic              valid;
    cause_t            cause;
    logic              high_prio;
    logic [BYTE_W-1:0] irq_ctrl_set;
    logic [BYTE_W-1:0] pir_set;
  } event_t;

  typedef struct packed {
    logic [BYTE_W-1:0] pins;
    logic [BYTE_W-1:0] latch;
    logic [BYTE_W-1:0] direction;
  } port_a_t;

endpackage : reset_init_pkg
